//--- smc_partner_model.sv
// Model of the analog supply comparator and the sleep state controller.
`timescale 1ns/1ps
`default_nettype none

module smc_partner_model #(
    parameter int READY_DLY = 6
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic want_below,
    input wire logic want_sleep,
    input wire logic monitor_enable,
    output logic deep_sleep,
    output logic warn_below_async,
    output logic monitor_ready_async
);
    int cnt;
    logic junk;

    ////////////////////////////////////////////////////////////////////////////
    // Sleep level, start-up delay of the analog monitor and a free toggle.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            cnt <= 0;
            junk <= 1'b0;
            deep_sleep <= 1'b0;
            monitor_ready_async <= 1'b0;
        end else begin
            deep_sleep <= want_sleep;
            junk <= ~junk;
            if (!monitor_enable) begin
                cnt <= 0;
            end else if (cnt < READY_DLY) begin
                cnt <= cnt + 1;
            end
            monitor_ready_async <= monitor_enable && (cnt >= READY_DLY);
        end
    end

    // An unpowered comparator gives no stable level, so it toggles.
    assign warn_below_async = monitor_enable ? want_below : junk;
endmodule

`default_nettype wire

//--- smc_pkg.sv
// Package of constants and types for the supply monitor control block.
package smc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Clock rate, sampling rates and the unlock window.
    localparam int unsigned SMC_CLK_HZ = 20_000_000;
    localparam int unsigned SMC_RATE_FAST_HZ = 128;
    localparam int unsigned SMC_RATE_SLOW_HZ = 32;
    localparam int unsigned SMC_FAST_CYCLES = SMC_CLK_HZ / SMC_RATE_FAST_HZ;
    localparam int unsigned SMC_SLOW_CYCLES = SMC_CLK_HZ / SMC_RATE_SLOW_HZ;
    localparam int unsigned SMC_DIV_W = 20;
    localparam logic [2:0] SMC_UNLOCK_INSTR = 3'h4;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] SMC_IDX_MODE_CTRL = 6'h00;
    localparam logic [5:0] SMC_IDX_TRIP_LEVEL = 6'h01;
    localparam logic [5:0] SMC_IDX_WARN_LEVEL = 6'h08;
    localparam logic [5:0] SMC_IDX_WARN_IRQ_CTRL = 6'h09;
    localparam logic [5:0] SMC_IDX_WARN_IRQ_FLAGS = 6'h0A;
    localparam logic [5:0] SMC_IDX_WARN_STATE = 6'h0B;
    localparam logic [5:0] SMC_IDX_IRQ_STATUS = 6'h0C;
    localparam logic [5:0] SMC_IDX_IRQ_CLEAR = 6'h0D;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int unsigned SMC_SLEEP_LSB = 0;
    localparam int unsigned SMC_AWAKE_LSB = 2;
    localparam int unsigned SMC_RATE_BIT = 4;
    localparam int unsigned SMC_TRIP_LSB = 0;
    localparam int unsigned SMC_MARGIN_LSB = 0;
    localparam int unsigned SMC_IE_BIT = 0;
    localparam int unsigned SMC_EDGE_LSB = 1;
    localparam int unsigned SMC_FLAG_BIT = 0;
    localparam int unsigned SMC_STATE_BIT = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values of the software fields.
    localparam logic [1:0] SMC_RST_MARGIN = 2'h0;
    localparam logic [1:0] SMC_RST_EDGE = 2'h0;
    localparam logic SMC_RST_IE = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Monitor modes, edge choices, margin codes and the power phase.
    typedef enum logic [1:0] {
        SMC_MODE_DIS = 2'h0,
        SMC_MODE_CONT = 2'h1,
        SMC_MODE_SAMP = 2'h2,
        SMC_MODE_WAKE = 2'h3
    } smc_mode_e;
    localparam logic [1:0] SMC_EDGE_FALL = 2'h0;
    localparam logic [1:0] SMC_EDGE_RISE = 2'h1;
    localparam logic [1:0] SMC_EDGE_BOTH = 2'h2;
    localparam logic [1:0] SMC_MARGIN_OFF = 2'h0;
    typedef enum logic [1:0] {
        SMC_PH_LOAD = 2'b00,
        SMC_PH_AWAKE = 2'b01,
        SMC_PH_SLEEP = 2'b11,
        SMC_PH_HOLD = 2'b10
    } smc_phase_e;

endpackage

//--- smc_supply_monitor_control.sv
// Supply drop monitor control, early warning logic and Wishbone registers.
//
// Contract
// - Sample rate bit picks sampled-mode check rate, 0 is 128 Hz, 1 is 32 Hz.
// - Sample rate, awake mode and sleep mode load from fuses at reset.
// - Awake mode field rules active/idle; 0 off,1 cont,2 sampled,3 wake hold.
// - Awake mode 3 holds execution after wake until the monitor runs.
// - Writable sleep mode field: 0 off, 1 continuous, 2 sampled, 3 reserved.
// - Three-bit trip level is read-only, fuse loaded, codes 0 to 3 valid.
// - Warning margin 0 disables warning; 1,2,3 give 5, 15, 25 percent.
// - Edge select: 0 falling below, 1 rising above, 2 either, 3 reserved.
// - Interrupt enable bit one enables the warning request, zero disables it.
// - Flag sets on each warning crossing of the selected kind.
// - Flag sets only while the monitor is enabled; otherwise it holds except for a software clear.
// - Warning state reads 0 above the warning threshold, 1 below it.
// - Deep sleep switches to the sleep mode; wake returns to awake mode.
// - Warning follows monitor mode: off when disabled, sampled when sampled.
// - Interrupt stands while flag and enable are set, until flag clears.
// - Protected bits change only within four instructions after the unlock key.
`timescale 1ns/1ps
`default_nettype none

module smc_supply_monitor_control
    import smc_pkg::*;
#(
    parameter int unsigned FAST_CYCLES = SMC_FAST_CYCLES,
    parameter int unsigned SLOW_CYCLES = SMC_SLOW_CYCLES
) (
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic fuse_sample_rate,
    input wire logic [1:0] fuse_awake_mode,
    input wire logic [1:0] fuse_sleep_mode,
    input wire logic [2:0] fuse_trip_level,
    input wire logic deep_sleep,
    input wire logic protection_unlock,
    input wire logic instr_retire,
    input wire logic warn_below_async,
    input wire logic monitor_ready_async,
    output logic monitor_enable,
    output logic monitor_sample,
    output logic [2:0] trip_level,
    output logic [1:0] warning_margin,
    output logic cpu_hold,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State of the block, one packed record.
    typedef struct packed {
        smc_phase_e phase;
        logic [1:0] awake_mode;
        logic [1:0] sleep_mode;
        logic sample_rate_select;
        logic [2:0] trip_level;
        logic [1:0] warning_margin;
        logic [1:0] warning_edge_select;
        logic warning_interrupt_enable;
        logic warning_interrupt_flag;
        logic warning_state_bit;
        logic [2:0] unlock_cnt;
        logic [SMC_DIV_W-1:0] div_cnt;
        logic sample;
        logic ack;
        logic [7:0] rdata;
        logic [1:0] warn_sync;
        logic [1:0] ready_sync;
    } smc_state_s;

    localparam smc_state_s SMC_STATE_RST = '{
        phase: SMC_PH_LOAD,
        awake_mode: 2'h0,
        sleep_mode: 2'h0,
        sample_rate_select: 1'b0,
        trip_level: 3'h0,
        warning_margin: SMC_RST_MARGIN,
        warning_edge_select: SMC_RST_EDGE,
        warning_interrupt_enable: SMC_RST_IE,
        warning_interrupt_flag: 1'b0,
        warning_state_bit: 1'b0,
        unlock_cnt: 3'h0,
        div_cnt: '0,
        sample: 1'b0,
        ack: 1'b0,
        rdata: 8'h00,
        warn_sync: 2'h0,
        ready_sync: 2'h0
    };

    localparam logic [SMC_DIV_W-1:0] FAST_LAST = SMC_DIV_W'(FAST_CYCLES - 1);
    localparam logic [SMC_DIV_W-1:0] SLOW_LAST = SMC_DIV_W'(SLOW_CYCLES - 1);

    smc_state_s state_reg;
    smc_state_s state_next;
    logic [1:0] mode_eff;
    logic mon_on;
    logic sampled;
    logic [SMC_DIV_W-1:0] period_last;
    logic eval;
    logic below_now;
    logic hit;
    logic set_flag;
    logic bus_req;
    logic bus_wr;
    logic [5:0] bus_idx;
    logic clear_req;

    ////////////////////////////////////////////////////////////////////////////
    // Mode in force, monitor enable, sampling period and warning evaluation.
    always_comb begin
        // Deep sleep uses the sleep field, all other phases the awake field.
        mode_eff = (state_reg.phase == SMC_PH_SLEEP) ? state_reg.sleep_mode
                                                    : state_reg.awake_mode;
        // The reserved sleep code acts as disabled.
        mon_on = (mode_eff != SMC_MODE_DIS) && !(state_reg.phase == SMC_PH_SLEEP
                 && mode_eff == SMC_MODE_WAKE) && (state_reg.phase != SMC_PH_LOAD);
        sampled = mon_on && (mode_eff == SMC_MODE_SAMP);
        period_last = state_reg.sample_rate_select ? SLOW_LAST : FAST_LAST;
        // The warning check runs on each sample in sampled mode, else every cycle.
        eval = mon_on && (state_reg.warning_margin != SMC_MARGIN_OFF)
               && (!sampled || state_reg.sample);
        below_now = state_reg.warn_sync[1];
        unique case (state_reg.warning_edge_select)
            SMC_EDGE_FALL: hit = below_now && !state_reg.warning_state_bit;
            SMC_EDGE_RISE: hit = !below_now && state_reg.warning_state_bit;
            SMC_EDGE_BOTH: hit = below_now != state_reg.warning_state_bit;
            default: hit = 1'b0;
        endcase
        set_flag = eval && hit;
    end

    // Bus request decode; a request is taken in the cycle before ack.
    assign bus_req = wb_cyc_i && wb_stb_i && !state_reg.ack;
    assign bus_wr = bus_req && wb_we_i && wb_sel_i[0] && (wb_adr_i[1:0] == 2'h0);
    assign bus_idx = wb_adr_i[7:2];
    assign clear_req = bus_wr && wb_dat_i[SMC_FLAG_BIT]
                       && (bus_idx == SMC_IDX_WARN_IRQ_FLAGS || bus_idx == SMC_IDX_IRQ_CLEAR);

    ////////////////////////////////////////////////////////////////////////////
    // Next state of the whole block.
    always_comb begin
        state_next = state_reg;
        state_next.ack = bus_req;
        state_next.warn_sync = {state_reg.warn_sync[0], warn_below_async};
        state_next.ready_sync = {state_reg.ready_sync[0], monitor_ready_async};

        // Power phase: fuse load after reset, then follow the sleep controller.
        unique case (state_reg.phase)
            SMC_PH_LOAD: begin
                state_next.sample_rate_select = fuse_sample_rate;
                state_next.awake_mode = fuse_awake_mode;
                state_next.sleep_mode = fuse_sleep_mode;
                state_next.trip_level = fuse_trip_level;
                state_next.phase = SMC_PH_AWAKE;
            end
            SMC_PH_AWAKE: begin
                if (deep_sleep) begin
                    state_next.phase = SMC_PH_SLEEP;
                end
            end
            SMC_PH_SLEEP: begin
                if (!deep_sleep) begin
                    state_next.phase = (state_reg.awake_mode == SMC_MODE_WAKE)
                                       ? SMC_PH_HOLD : SMC_PH_AWAKE;
                end
            end
            SMC_PH_HOLD: begin
                if (state_reg.ready_sync[1]) begin
                    state_next.phase = SMC_PH_AWAKE;
                end
            end
        endcase

        // Sample divider runs only in sampled mode and restarts otherwise.
        if (sampled && state_reg.div_cnt < period_last) begin
            state_next.div_cnt = state_reg.div_cnt + SMC_DIV_W'(1);
        end else begin
            state_next.div_cnt = '0;
        end
        state_next.sample = sampled && (state_reg.div_cnt >= period_last);

        // Unlock window counts retired instructions after the key.
        if (protection_unlock) begin
            state_next.unlock_cnt = SMC_UNLOCK_INSTR;
        end else if (instr_retire && state_reg.unlock_cnt != 3'h0) begin
            state_next.unlock_cnt = state_reg.unlock_cnt - 3'h1;
        end

        // Register writes; the awake mode and trip level have no write path.
        if (bus_wr) begin
            unique case (bus_idx)
                SMC_IDX_MODE_CTRL: begin
                    if (state_reg.unlock_cnt != 3'h0) begin
                        state_next.sleep_mode = wb_dat_i[SMC_SLEEP_LSB +: 2];
                    end
                end
                SMC_IDX_WARN_LEVEL: begin
                    state_next.warning_margin = wb_dat_i[SMC_MARGIN_LSB +: 2];
                end
                SMC_IDX_WARN_IRQ_CTRL: begin
                    state_next.warning_interrupt_enable = wb_dat_i[SMC_IE_BIT];
                    state_next.warning_edge_select = wb_dat_i[SMC_EDGE_LSB +: 2];
                end
                default: begin
                end
            endcase
        end

        // Flag clears on a one, and a crossing in the same cycle wins.
        if (clear_req) begin
            state_next.warning_interrupt_flag = 1'b0;
        end
        if (set_flag) begin
            state_next.warning_interrupt_flag = 1'b1;
        end
        if (eval) begin
            state_next.warning_state_bit = below_now;
        end

        // Read data is captured when the request is taken.
        state_next.rdata = 8'h00;
        if (bus_req && !wb_we_i && wb_adr_i[1:0] == 2'h0) begin
            unique case (bus_idx)
                SMC_IDX_MODE_CTRL: begin
                    state_next.rdata[SMC_RATE_BIT] = state_reg.sample_rate_select;
                    state_next.rdata[SMC_AWAKE_LSB +: 2] = state_reg.awake_mode;
                    state_next.rdata[SMC_SLEEP_LSB +: 2] = state_reg.sleep_mode;
                end
                SMC_IDX_TRIP_LEVEL: begin
                    state_next.rdata[SMC_TRIP_LSB +: 3] = state_reg.trip_level;
                end
                SMC_IDX_WARN_LEVEL: begin
                    state_next.rdata[SMC_MARGIN_LSB +: 2] = state_reg.warning_margin;
                end
                SMC_IDX_WARN_IRQ_CTRL: begin
                    state_next.rdata[SMC_IE_BIT] = state_reg.warning_interrupt_enable;
                    state_next.rdata[SMC_EDGE_LSB +: 2] = state_reg.warning_edge_select;
                end
                SMC_IDX_WARN_IRQ_FLAGS, SMC_IDX_IRQ_STATUS: begin
                    state_next.rdata[SMC_FLAG_BIT] = state_reg.warning_interrupt_flag;
                end
                SMC_IDX_WARN_STATE: begin
                    state_next.rdata[SMC_STATE_BIT] = state_reg.warning_state_bit;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            state_reg <= SMC_STATE_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs.
    assign wb_ack_o = state_reg.ack;
    assign wb_dat_o = {24'h000000, state_reg.rdata};
    assign monitor_enable = mon_on;
    assign monitor_sample = state_reg.sample;
    assign trip_level = state_reg.trip_level;
    assign warning_margin = state_reg.warning_margin;
    assign cpu_hold = (state_reg.phase == SMC_PH_HOLD);
    // Level request while flag and enable are both set.
    assign irq = state_reg.warning_interrupt_flag
                 && state_reg.warning_interrupt_enable;

    ////////////////////////////////////////////////////////////////////////////
    // Checks on the behaviour above.
    default clocking smc_cb @(posedge sys_clk);
    endclocking
    default disable iff (reset);

    sequence smc_wake_seq;
        state_reg.phase == SMC_PH_SLEEP ##1 !deep_sleep
            && state_reg.awake_mode == SMC_MODE_WAKE;
    endsequence

    sequence smc_plain_wake_seq;
        state_reg.phase == SMC_PH_SLEEP && !deep_sleep
            && state_reg.awake_mode != SMC_MODE_WAKE;
    endsequence

    sequence smc_locked_write_seq;
        bus_wr && bus_idx == SMC_IDX_MODE_CTRL && state_reg.unlock_cnt == 3'h0;
    endsequence

    AST_RATE_PERIOD: assert property (
        state_reg.sample |-> $past(state_reg.div_cnt) == $past(period_last))
        else $error("sample pulse not at end of rate period");
    AST_FUSE_LOAD: assert property (
        state_reg.phase == SMC_PH_LOAD |=> state_reg.awake_mode == $past(fuse_awake_mode)
            && state_reg.sleep_mode == $past(fuse_sleep_mode)
            && state_reg.sample_rate_select == $past(fuse_sample_rate))
        else $error("fuse values not loaded");
    AST_AWAKE_FIXED: assert property (
        state_reg.phase != SMC_PH_LOAD |=> $stable(state_reg.awake_mode)
            && $stable(state_reg.trip_level))
        else $error("read-only field changed");
    AST_WAKE_HOLD: assert property (
        smc_wake_seq |=> cpu_hold)
        else $error("no hold after wake");
    AST_HOLD_RELEASE: assert property (
        cpu_hold && state_reg.ready_sync[1] |=> !cpu_hold ##1 !cpu_hold)
        else $error("hold not released once monitor runs");
    AST_LOCKED: assert property (
        smc_locked_write_seq |=> $stable(state_reg.sleep_mode))
        else $error("protected field written while locked");
    AST_DISABLED_HOLD: assert property (
        !mon_on && !clear_req |=> $stable(state_reg.warning_interrupt_flag)
            && $stable(state_reg.warning_state_bit))
        else $error("flag moved while monitor disabled");
    AST_MARGIN_OFF: assert property (
        state_reg.warning_margin == SMC_MARGIN_OFF |=> !$rose(state_reg.warning_interrupt_flag))
        else $error("flag set with warning off");
    AST_SET_WINS: assert property (
        set_flag |=> state_reg.warning_interrupt_flag && irq == state_reg.warning_interrupt_enable)
        else $error("crossing lost");
    AST_CLEAR: assert property (
        clear_req && !set_flag |=> !state_reg.warning_interrupt_flag && !irq)
        else $error("flag not cleared by one");
    AST_STATE_BIT: assert property (
        eval |=> state_reg.warning_state_bit == $past(state_reg.warn_sync[1]))
        else $error("warning state not tracking comparator");
    AST_SAMPLED_ONLY: assert property (
        sampled && !state_reg.sample |-> !eval)
        else $error("warning evaluated between samples");
    AST_SLEEP_MODE: assert property (
        state_reg.phase == SMC_PH_SLEEP |-> monitor_enable == (state_reg.sleep_mode
            == SMC_MODE_CONT || state_reg.sleep_mode == SMC_MODE_SAMP))
        else $error("sleep mode not in force");
    AST_ACK_PULSE: assert property (
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");

    // Further checks on fuse load, power phases, unlock, edge codes and the bus answer.
    AST_LOAD_OFF: assert property (
        state_reg.phase == SMC_PH_LOAD |-> !monitor_enable && !monitor_sample)
        else $error("monitor on before fuse load");
    AST_SLEEP_ENTRY: assert property (
        state_reg.phase == SMC_PH_AWAKE && deep_sleep |=> state_reg.phase == SMC_PH_SLEEP)
        else $error("sleep entry missed");
    AST_PLAIN_WAKE: assert property (
        smc_plain_wake_seq |=> state_reg.phase == SMC_PH_AWAKE && !cpu_hold)
        else $error("no return to awake mode");
    AST_UNLOCKED_WRITE: assert property (
        bus_wr && bus_idx == SMC_IDX_MODE_CTRL && state_reg.unlock_cnt != 3'h0
            |=> state_reg.sleep_mode == $past(wb_dat_i[SMC_SLEEP_LSB +: 2]))
        else $error("unlocked sleep mode write lost");
    AST_SAMPLE_MODE: assert property (
        monitor_sample |-> $past(sampled))
        else $error("sample pulse outside sampled mode");
    AST_RESERVED_EDGE: assert property (
        state_reg.warning_edge_select == 2'h3 |-> !set_flag)
        else $error("reserved edge code set the flag");
    AST_ACK_NEXT: assert property (
        bus_req |=> wb_ack_o && wb_dat_o[31:8] == 24'h000000)
        else $error("request not answered in the next cycle");

endmodule

`default_nettype wire

//--- smc_supply_monitor_control_test.sv
// Self-checking testbench of the supply monitor control block.
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end

module smc_supply_monitor_control_test;
    import smc_pkg::*;
    logic sys_clk, reset, wb_cyc, wb_stb, wb_we;
    logic [7:0] wb_adr;
    logic [3:0] wb_sel;
    logic [31:0] wb_dat, wb_dat_o, rd;
    logic wb_ack_o, f_rate, deep_sleep, unlock, retire, below_a, ready_a;
    logic [1:0] f_awake, f_sleep, warning_margin;
    logic [2:0] trip_level, f_trip;
    logic monitor_enable, monitor_sample, cpu_hold, irq, want_below, want_sleep;
    int err_total = 0;
    int num_checks = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Design, partner and clock.
    smc_supply_monitor_control #(.FAST_CYCLES(8), .SLOW_CYCLES(32)) smc_supply_monitor_control_i (
        .sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .fuse_sample_rate(f_rate),
        .fuse_awake_mode(f_awake), .fuse_sleep_mode(f_sleep), .fuse_trip_level(f_trip),
        .deep_sleep(deep_sleep), .protection_unlock(unlock), .instr_retire(retire),
        .warn_below_async(below_a), .monitor_ready_async(ready_a),
        .monitor_enable(monitor_enable), .monitor_sample(monitor_sample),
        .trip_level(trip_level), .warning_margin(warning_margin), .cpu_hold(cpu_hold),
        .irq(irq));
    smc_partner_model smc_partner_model_i (.sys_clk(sys_clk), .reset(reset),
        .want_below(want_below), .want_sleep(want_sleep), .monitor_enable(monitor_enable),
        .deep_sleep(deep_sleep), .warn_below_async(below_a), .monitor_ready_async(ready_a));

    // Free-running clock of 50 ns.
    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks.
    task automatic final_report();
        if (err_total == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Counts a mismatch and ends the run when a wait used up its bound.
    task automatic bound(input int n);
        if (n >= 100) begin
            err_total++;
            final_report();
        end
    endtask

    // One classic Wishbone cycle; the request stands until ack is sampled.
    task automatic bus(input logic we, input logic [5:0] idx, input logic [7:0] wd);
        int n;
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= {idx, 2'h0};
        wb_dat <= {24'h000000, wd}; wb_sel <= 4'hF;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (wb_ack_o !== 1'b1 && n < 100);
        bound(n);
        rd = wb_dat_o;
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
        @(posedge sys_clk);
    endtask

    // Reset with the given fuse levels, held for five cycles.
    task automatic rst(input logic [1:0] aw, input logic [1:0] sl, input logic rt);
        f_awake <= aw; f_sleep <= sl; f_rate <= rt; reset <= 1'b1;
        // The trip fuse follows the sleep code, so the five resets load levels 2, 1, 0, 0 and 0.
        f_trip <= {1'b0, sl};
        // The supply starts above the warning level, so no stale crossing follows reset.
        want_below <= 1'b0;
        repeat (5) @(posedge sys_clk);
        reset <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask

    // Pulses a one-cycle strobe on the unlock or the retire input.
    task automatic pulse(input bit u);
        if (u) unlock <= 1'b1; else retire <= 1'b1;
        @(posedge sys_clk);
        unlock <= 1'b0; retire <= 1'b0;
        @(posedge sys_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_regs();
        rst(2'h1, 2'h2, 1'b1);
        bus(0, SMC_IDX_MODE_CTRL, 8'h00); `CHK(rd, 32'h00000016)
        bus(1, SMC_IDX_TRIP_LEVEL, 8'hFF);
        bus(0, SMC_IDX_TRIP_LEVEL, 8'h00); `CHK(rd, 32'h00000002)
        `CHK(trip_level, 3'h2)
        for (int i = 8; i < 12; i++) begin
            bus(0, 6'(i), 8'h00); `CHK(rd, 32'h00000000)
        end
        bus(0, 6'h03, 8'h00); `CHK(rd, 32'h00000000)
        bus(1, SMC_IDX_MODE_CTRL, 8'h1F);
        bus(0, SMC_IDX_MODE_CTRL, 8'h00); `CHK(rd, 32'h00000016)
        pulse(1);
        bus(1, SMC_IDX_MODE_CTRL, 8'h01);
        bus(0, SMC_IDX_MODE_CTRL, 8'h00); `CHK(rd, 32'h00000015)
        repeat (4) pulse(0);
        bus(1, SMC_IDX_MODE_CTRL, 8'h02);
        bus(0, SMC_IDX_MODE_CTRL, 8'h00); `CHK(rd, 32'h00000015)
    endtask

    // Sets margin and control, moves the supply, then judges and clears the flag.
    task automatic step(input logic [7:0] ctl, input logic [1:0] mg, input logic bl,
        input logic ef, input logic ei);
        bus(1, SMC_IDX_WARN_LEVEL, {6'h00, mg});
        bus(1, SMC_IDX_WARN_IRQ_CTRL, ctl);
        `CHK(warning_margin, mg)
        want_below <= bl;
        repeat (6) @(posedge sys_clk);
        `CHK(irq, ei)
        bus(1, SMC_IDX_WARN_IRQ_FLAGS, 8'h00);
        bus(0, SMC_IDX_WARN_IRQ_FLAGS, 8'h00); `CHK(rd[0], ef)
        bus(0, SMC_IDX_IRQ_STATUS, 8'h00); `CHK(rd[0], ef)
        if (mg != SMC_MARGIN_OFF) begin
            bus(0, SMC_IDX_WARN_STATE, 8'h00); `CHK(rd[0], bl)
        end
        bus(1, ctl[0] ? SMC_IDX_WARN_IRQ_FLAGS : SMC_IDX_IRQ_CLEAR, 8'h01);
        bus(0, SMC_IDX_IRQ_STATUS, 8'h00); `CHK(rd[0], 1'b0)
        `CHK(irq, 1'b0)
    endtask

    task automatic t_warn();
        rst(2'h1, 2'h1, 1'b0);
        step(8'h01, 2'h1, 1'b1, 1'b1, 1'b1);
        step(8'h03, 2'h2, 1'b0, 1'b1, 1'b1);
        step(8'h00, 2'h3, 1'b1, 1'b1, 1'b0);
        step(8'h06, 2'h1, 1'b0, 1'b0, 1'b0);
        step(8'h04, 2'h0, 1'b1, 1'b0, 1'b0);
        step(8'h05, 2'h3, 1'b1, 1'b1, 1'b1);
    endtask

    // Sleep with the monitor off, then wake into the hold phase.
    task automatic t_sleep();
        int n;
        rst(2'h3, 2'h0, 1'b0);
        step(8'h05, 2'h1, 1'b0, 1'b0, 1'b0);
        want_sleep <= 1'b1;
        repeat (4) @(posedge sys_clk);
        `CHK(monitor_enable, 1'b0)
        repeat (10) @(posedge sys_clk);
        bus(0, SMC_IDX_WARN_IRQ_FLAGS, 8'h00); `CHK(rd[0], 1'b0)
        want_sleep <= 1'b0;
        repeat (3) @(posedge sys_clk);
        `CHK(cpu_hold, 1'b1)
        n = 0;
        do begin @(posedge sys_clk); n++; end while (cpu_hold !== 1'b0 && n < 100);
        bound(n);
        `CHK(ready_a, 1'b1)
        `CHK(monitor_enable, 1'b1)
    endtask

    // Measures the distance between two sample pulses.
    task automatic period(input logic rt, input int ex);
        int n;
        rst(2'h2, 2'h0, rt);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            do begin @(posedge sys_clk); n++; end while (monitor_sample !== 1'b1 && n < 100);
            bound(n);
        end
        `CHK(n, ex)
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        reset <= 1'b1; wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0; wb_adr <= 8'h00;
        wb_sel <= 4'h0; wb_dat <= 32'h00000000; f_rate <= 1'b0; f_awake <= 2'h0;
        f_sleep <= 2'h0; unlock <= 1'b0; retire <= 1'b0; want_below <= 1'b0;
        want_sleep <= 1'b0; f_trip <= 3'h0;
        t_regs();
        t_warn();
        t_sleep();
        period(1'b0, 8);
        period(1'b1, 32);
        final_report();
    end
endmodule

`default_nettype wire
